// [verilog/eeprom_guard_host.sv]
// host controller driving a protected serial eeprom, ordered over ahb-lite
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module eeprom_guard_host #(
   parameter int ADDR_W = eeprom_host_pkg::ADDR_W_DEF,
   parameter int HALF_DIV = eeprom_host_pkg::HALF_DIV_DEF,
   parameter int POLL_MAX_CYC = eeprom_host_pkg::POLL_MAX_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_sel,
   output logic o_sck,
   output logic o_di,
   output logic o_wp,
   output logic o_gs,
   input wire logic i_do
);
   if (!(ADDR_W == 6 || ADDR_W == 8)) begin : g_bad_addr
      $error("address width must be 6 or 8");
   end
   if (POLL_MAX_CYC < 2) begin : g_bad_poll
      $error("poll limit too small");
   end
   localparam int FR_W = eeprom_host_pkg::FR_W;
   localparam int PAD = FR_W - 3 - ADDR_W - 4 * eeprom_host_pkg::DATA_W;

   typedef struct packed {
      eeprom_host_pkg::state_e state;
      eeprom_host_pkg::cmd_kind_e kind; // command in flight
      logic [7:0] addr; // its address
      logic [1:0] npg; // page words minus one
      logic auto_lock; // send program lock after ready
      logic [63:0] words; // word 0 in the low half-word
      logic [FR_W-1:0] frame; // outgoing bits, msb first
      logic [6:0] nbits; // clock pulses in the frame
      logic [6:0] cap; // first pulse whose end is sampled
      logic rd; // frame returns data
      logic prog; // frame starts a programming cycle
      logic [6:0] cnt; // pulses done
      logic [31:0] rx; // returned bits, last in lsb
      logic [31:0] wait_cnt; // gap and poll timer
      logic refused; // last order refused
      logic timeout; // ready never came
      logic prog_on; // program unlock sent, no lock since
      logic armed; // last command was guard unlock
      logic wr_pend; // ahb write data phase pending
      logic [7:0] wr_ofs; // its offset
      logic [31:0] hrdata;
      logic hready_o;
      logic hresp;
      logic run; // divider runs
      logic sel;
      logic sck;
      logic di;
      logic wp;
      logic gs;
   } host_s;
   host_s st;
   host_s next_st;
   logic do_s; // synchronised device output
   ser_tick_if tk();

   bit_sync u_do_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_async(i_do),
      .o_sync(do_s)
   );

   ser_clk_div #(.HALF_DIV(HALF_DIV)) u_div (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .tk(tk.gen)
   );

   assign tk.run = st.run;

   // guard-modifying commands need the unlock pair first
   function automatic logic is_gmod(input eeprom_host_pkg::cmd_kind_e k);
      is_gmod = k == eeprom_host_pkg::K_GUARD_SET || k == eeprom_host_pkg::K_GUARD_RESET
         || k == eeprom_host_pkg::K_GUARD_FREEZE;
   endfunction

   // load a frame for one command and start it
   function automatic host_s launch(input host_s s, input eeprom_host_pkg::cmd_kind_e k,
         input logic [7:0] a, input logic [1:0] n);
      logic [1:0] op;
      logic [ADDR_W-1:0] ad;
      logic [6:0] dn;
      logic [6:0] rn;
      logic [63:0] dat;
      op = eeprom_host_pkg::OP_SYS;
      ad = a[ADDR_W-1:0];
      dn = '0;
      rn = '0;
      s.wp = 1'b0;
      s.gs = 1'b0;
      s.prog = 1'b0;
      case (k)
         eeprom_host_pkg::K_PROG_UNLOCK: begin
            ad = {eeprom_host_pkg::SUB_UNLOCK, {(ADDR_W-2){1'b0}}};
            s.wp = 1'b1;
         end
         eeprom_host_pkg::K_PROG_LOCK: begin
            ad = '0;
         end
         eeprom_host_pkg::K_WORD_PROG: begin
            op = eeprom_host_pkg::OP_WORD;
            dn = 7'(eeprom_host_pkg::DATA_W);
            s.wp = 1'b1;
            s.prog = 1'b1;
         end
         eeprom_host_pkg::K_PAGE_PROG: begin
            op = eeprom_host_pkg::OP_PAGE;
            dn = 7'(eeprom_host_pkg::DATA_W) * (7'(n) + 7'h01);
            s.wp = 1'b1;
            s.prog = 1'b1;
         end
         eeprom_host_pkg::K_BULK_FILL: begin
            ad = {eeprom_host_pkg::SUB_BULK, {(ADDR_W-2){1'b0}}};
            dn = 7'(eeprom_host_pkg::DATA_W);
            s.wp = 1'b1;
            s.prog = 1'b1;
         end
         eeprom_host_pkg::K_ARRAY_READ: begin
            op = eeprom_host_pkg::OP_READ;
            rn = 7'(eeprom_host_pkg::DATA_W);
         end
         eeprom_host_pkg::K_GUARD_FETCH: begin
            op = eeprom_host_pkg::OP_READ;
            ad = '0;
            rn = 7'(ADDR_W + 1);
            s.gs = 1'b1;
         end
         eeprom_host_pkg::K_GUARD_SET: begin
            op = eeprom_host_pkg::OP_WORD;
            s.gs = 1'b1;
            s.wp = 1'b1;
            s.prog = 1'b1;
         end
         eeprom_host_pkg::K_GUARD_RESET: begin
            op = eeprom_host_pkg::OP_PAGE;
            ad = '1;
            s.gs = 1'b1;
            s.wp = 1'b1;
            s.prog = 1'b1;
         end
         eeprom_host_pkg::K_GUARD_UNLOCK: begin
            ad = {eeprom_host_pkg::SUB_UNLOCK, {(ADDR_W-2){1'b0}}};
            s.gs = 1'b1;
            s.wp = 1'b1;
         end
         eeprom_host_pkg::K_GUARD_FREEZE: begin
            ad = '0;
            s.gs = 1'b1;
            s.wp = 1'b1;
            s.prog = 1'b1;
         end
         default: ;
      endcase
      // word 0 goes out first, msb first
      dat = {s.words[15:0], s.words[31:16], s.words[47:32], s.words[63:48]};
      if (dn == 7'h00) begin
         dat = '0;
      end
      s.frame = {1'b1, op, ad, dat, {PAD{1'b0}}};
      s.nbits = 7'(3 + ADDR_W) + dn + rn;
      s.cap = 7'(2 + ADDR_W);
      s.rd = rn != 7'h00;
      s.kind = k;
      s.addr = a;
      s.npg = n;
      s.auto_lock = 1'b0;
      s.armed = k == eeprom_host_pkg::K_GUARD_UNLOCK;
      if (k == eeprom_host_pkg::K_PROG_UNLOCK) begin
         s.prog_on = 1'b1;
      end else if (k == eeprom_host_pkg::K_PROG_LOCK) begin
         s.prog_on = 1'b0;
      end
      s.cnt = '0;
      s.rx = '0;
      s.wait_cnt = '0;
      s.run = 1'b1;
      s.state = eeprom_host_pkg::S_PREP;
      return s;
   endfunction

   // bus slave, order check and serial sequencer
   always_comb begin
      logic ap;
      logic req;
      logic bad;
      logic [31:0] rdm;
      eeprom_host_pkg::cmd_kind_e k;
      ap = i_hsel && i_htrans[1] && i_hready;
      req = 1'b0;
      bad = 1'b0;
      rdm = '0;
      k = eeprom_host_pkg::cmd_kind_e'(i_hwdata[eeprom_host_pkg::CMD_KIND_LSB+:4]);
      next_st = st;
      next_st.hready_o = 1'b1; // zero wait states
      next_st.hresp = 1'b0; // always okay
      // read mux, sampled in the address phase
      if (i_haddr[31:8] == 24'h000000) begin
         case (i_haddr[7:0])
            eeprom_host_pkg::OFS_CMD: rdm = {16'h0000, st.addr, 1'b0, st.auto_lock, st.npg, st.kind};
            eeprom_host_pkg::OFS_WD01: rdm = st.words[31:0];
            eeprom_host_pkg::OFS_WD23: rdm = st.words[63:32];
            eeprom_host_pkg::OFS_STAT: rdm = {27'h0, st.armed, st.prog_on, st.timeout, st.refused,
               st.state != eeprom_host_pkg::S_IDLE};
            eeprom_host_pkg::OFS_RDAT: rdm = st.rx;
            default: rdm = '0;
         endcase
      end
      if (ap && !i_hwrite) begin
         next_st.hrdata = rdm;
      end
      next_st.wr_pend = ap && i_hwrite && i_haddr[31:8] == 24'h000000;
      next_st.wr_ofs = i_haddr[7:0];
      // write data phase
      if (st.wr_pend) begin
         case (st.wr_ofs)
            eeprom_host_pkg::OFS_WD01: next_st.words[31:0] = i_hwdata;
            eeprom_host_pkg::OFS_WD23: next_st.words[63:32] = i_hwdata;
            eeprom_host_pkg::OFS_CMD: req = 1'b1;
            default: ;
         endcase
      end
      // an order is refused whole, nothing reaches the pins
      if (req) begin
         bad = st.state != eeprom_host_pkg::S_IDLE
            || i_hwdata[eeprom_host_pkg::CMD_KIND_LSB+:4] > eeprom_host_pkg::K_ARRAY_READ
            || (k == eeprom_host_pkg::K_PAGE_PROG
               && {1'b0, i_hwdata[eeprom_host_pkg::CMD_ADDR_LSB+:2]}
               + {1'b0, i_hwdata[eeprom_host_pkg::CMD_NPG_LSB+:2]} > 3'h3)
            || (is_gmod(k) && !st.armed)
            || (k == eeprom_host_pkg::K_GUARD_UNLOCK && !st.prog_on);
         if (bad) begin
            next_st.refused = 1'b1;
         end else begin
            next_st = launch(next_st, k, i_hwdata[eeprom_host_pkg::CMD_ADDR_LSB+:8],
               i_hwdata[eeprom_host_pkg::CMD_NPG_LSB+:2]);
            next_st.auto_lock = i_hwdata[eeprom_host_pkg::CMD_LOCK_BIT] && next_st.prog;
            next_st.refused = 1'b0;
            next_st.timeout = 1'b0;
         end
      end
      case (st.state)
         eeprom_host_pkg::S_IDLE: ;
         // pins settle until the next tick, a full half period when started from idle, then select rises with clock low
         eeprom_host_pkg::S_PREP: begin
            if (tk.tick) begin
               next_st.sel = 1'b1;
               next_st.di = st.frame[FR_W-1];
               next_st.state = eeprom_host_pkg::S_LO;
            end
         end
         eeprom_host_pkg::S_LO: begin
            if (tk.tick) begin
               next_st.sck = 1'b1;
               next_st.state = eeprom_host_pkg::S_HI;
            end
         end
         // end of high half: sample, count, then next bit or deselect
         eeprom_host_pkg::S_HI: begin
            if (tk.tick) begin
               next_st.sck = 1'b0;
               next_st.cnt = st.cnt + 7'h01;
               if (st.rd && st.cnt >= st.cap) begin
                  next_st.rx = {st.rx[30:0], do_s};
               end
               if (st.cnt + 7'h01 == st.nbits) begin
                  next_st.sel = 1'b0;
                  next_st.di = 1'b0;
                  next_st.wait_cnt = '0;
                  next_st.state = eeprom_host_pkg::S_GAP;
               end else begin
                  next_st.frame = st.frame << 1;
                  next_st.di = st.frame[FR_W-2];
                  next_st.state = eeprom_host_pkg::S_LO;
               end
            end
         end
         // deselect gap; clock stays low so no stray pulse is counted
         eeprom_host_pkg::S_GAP: begin
            if (st.wait_cnt == 32'(eeprom_host_pkg::GAP_CYC - 1)) begin
               next_st.wait_cnt = '0;
               if (st.prog) begin
                  next_st.sel = 1'b1;
                  next_st.state = eeprom_host_pkg::S_POLL;
               end else if (st.auto_lock) begin
                  next_st = launch(next_st, eeprom_host_pkg::K_PROG_LOCK, 8'h00, 2'h0);
               end else begin
                  next_st.run = 1'b0;
                  next_st.wp = 1'b0;
                  next_st.gs = 1'b0;
                  next_st.state = eeprom_host_pkg::S_IDLE;
               end
            end else begin
               next_st.wait_cnt = st.wait_cnt + 32'h1;
            end
         end
         // selected with clock stopped; the device times itself
         eeprom_host_pkg::S_POLL: begin
            next_st.wait_cnt = st.wait_cnt + 32'h1;
            if (tk.tick && st.wait_cnt >= 32'(HALF_DIV) && do_s) begin
               next_st.prog = 1'b0;
               next_st.sel = 1'b0;
               next_st.wait_cnt = '0;
               next_st.state = eeprom_host_pkg::S_GAP;
            end else if (st.wait_cnt == 32'(POLL_MAX_CYC - 1)) begin
               next_st.timeout = 1'b1; // frozen guard shows no status
               next_st.prog = 1'b0;
               next_st.sel = 1'b0;
               next_st.wait_cnt = '0;
               next_st.state = eeprom_host_pkg::S_GAP;
            end
         end
         default: next_st.state = eeprom_host_pkg::S_IDLE;
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
         st.hready_o <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_hrdata = st.hrdata;
   assign o_hreadyout = st.hready_o;
   assign o_hresp = st.hresp;
   assign o_sel = st.sel;
   assign o_sck = st.sck;
   assign o_di = st.di;
   assign o_wp = st.wp;
   assign o_gs = st.gs;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   chk_rise_selected: assert property ($rose(o_sck) |-> o_sel)
      else $error("clock rose while deselected");
   chk_start_bit: assert property ($rose(o_sck) && st.cnt == 7'h00 |-> o_di)
      else $error("first pulse not a start bit");
   chk_deselect_win: assert property (st.state == eeprom_host_pkg::S_HI && tk.tick
      && st.cnt + 7'h01 == st.nbits |=> !o_sel && !o_sck ##1 !o_sck)
      else $error("select not dropped after last bit");
   chk_pulse_total: assert property ($fell(o_sel) && $past(st.state) == eeprom_host_pkg::S_HI
      |-> st.cnt == st.nbits)
      else $error("pulse count differs from frame length");
   chk_prog_permit: assert property (o_sel && (st.kind == eeprom_host_pkg::K_WORD_PROG
      || st.kind == eeprom_host_pkg::K_PAGE_PROG || st.kind == eeprom_host_pkg::K_BULK_FILL) |-> o_wp)
      else $error("write-permit low during programming");
   chk_guard_pins: assert property (o_sel && is_gmod(st.kind) |-> o_gs && o_wp)
      else $error("guard pins low during guard command");
   chk_guard_order: assert property ($rose(st.state == eeprom_host_pkg::S_PREP) && is_gmod(st.kind)
      |-> $past(st.armed) && $past(st.prog_on))
      else $error("guard command without unlock pair");
   chk_page_group: assert property (st.state == eeprom_host_pkg::S_PREP
      && st.kind == eeprom_host_pkg::K_PAGE_PROG |-> {1'b0, st.addr[1:0]} + {1'b0, st.npg} <= 3'h3)
      else $error("page crosses an address group");
   chk_poll_quiet: assert property (st.state == eeprom_host_pkg::S_POLL |-> o_sel && !o_sck)
      else $error("poll not selected with clock low");
   chk_fetch_len: assert property ($rose(o_sel) && st.kind == eeprom_host_pkg::K_GUARD_FETCH
      |-> st.nbits == 7'(4 + 2 * ADDR_W) && o_gs)
      else $error("fetch frame malformed");

   cov_word_ready: cover property (st.kind == eeprom_host_pkg::K_WORD_PROG
      && $fell(st.state == eeprom_host_pkg::S_POLL) && !st.timeout);
   cov_page_four: cover property (st.kind == eeprom_host_pkg::K_PAGE_PROG && st.npg == 2'h3
      && $rose(o_sel));
   cov_fetch_done: cover property (st.kind == eeprom_host_pkg::K_GUARD_FETCH && $fell(st.run));
   cov_auto_lock: cover property (st.kind == eeprom_host_pkg::K_PROG_LOCK
      && $past(st.state) == eeprom_host_pkg::S_GAP && st.state == eeprom_host_pkg::S_PREP);
endmodule

// [verilog/eeprom_host_pkg.sv]
// constants, register map and enumerations of the serial eeprom host
package eeprom_host_pkg;
   localparam int CLK_MHZ = 200; // system clock rate
   localparam int ADDR_W_DEF = 8; // 8 on larger densities, 6 on the smallest
   localparam int HALF_DIV_DEF = 50; // serial clock half period, system clocks
   localparam int T_DESEL_NS = 250; // deselect_gap_time, least value
   localparam int GAP_CYC = (T_DESEL_NS * CLK_MHZ + 999) / 1000; // rounded up
   localparam int T_POLL_MAX_US = 10000; // longest wait for ready
   localparam int POLL_MAX_CYC = T_POLL_MAX_US * CLK_MHZ; // rounded down
   localparam int FR_W = 80; // frame shifter width
   localparam int DATA_W = 16; // array word width
   // register offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_WD01 = 8'h04;
   localparam logic [7:0] OFS_WD23 = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   localparam logic [7:0] OFS_RDAT = 8'h10;
   // command register fields
   localparam int CMD_KIND_LSB = 0;
   localparam int CMD_NPG_LSB = 4;
   localparam int CMD_LOCK_BIT = 6;
   localparam int CMD_ADDR_LSB = 8;
   // opcodes and sub-codes in the two top address bits
   localparam logic [1:0] OP_SYS = 2'h0;
   localparam logic [1:0] OP_WORD = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_PAGE = 2'h3;
   localparam logic [1:0] SUB_UNLOCK = 2'h3;
   localparam logic [1:0] SUB_BULK = 2'h1;
   typedef enum logic [3:0] {
      K_PROG_UNLOCK = 4'h0, K_PROG_LOCK = 4'h1, K_WORD_PROG = 4'h2,
      K_PAGE_PROG = 4'h3, K_BULK_FILL = 4'h4, K_GUARD_FETCH = 4'h5,
      K_GUARD_SET = 4'h6, K_GUARD_RESET = 4'h7, K_GUARD_UNLOCK = 4'h8,
      K_GUARD_FREEZE = 4'h9, K_ARRAY_READ = 4'ha
   } cmd_kind_e;
   // gray steps along prep, low, high, gap, poll
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_PREP = 3'h1, S_LO = 3'h3, S_HI = 3'h2, S_GAP = 3'h6, S_POLL = 3'h7
   } state_e;
endpackage

// [verilog/ser_tick_if.sv]
// run request and half-period tick between host and its clock divider
`timescale 1ns/1ps
interface ser_tick_if;
   logic run; // divider may count
   logic tick; // one-cycle half-period enable
   modport gen(input run, output tick);
   modport ctl(output run, input tick);
endinterface

// [verilog/bit_sync.sv]
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module bit_sync (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_async,
   output logic o_sync
);
   typedef struct packed {
      logic meta; // first stage, read only by the second
      logic sync; // second stage
   } sync_s;
   sync_s st;
   sync_s next_st;

   // shift the pin through two stages
   always_comb begin
      next_st.meta = i_async;
      next_st.sync = st.meta;
   end

   // register with synchronous reset
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_sync = st.sync;
endmodule

// [verilog/ser_clk_div.sv]
// divider giving one tick per serial clock half period
`timescale 1ns/1ps
module ser_clk_div #(
   parameter int HALF_DIV = eeprom_host_pkg::HALF_DIV_DEF
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   ser_tick_if.gen tk
);
   if (HALF_DIV < 4 || HALF_DIV > 65535) begin : g_bad_div
      $error("half period must be 4 to 65535 cycles");
   end
   typedef struct packed {
      logic [15:0] cnt; // cycles into the half period
      logic tick; // registered enable
   } div_s;
   div_s st;
   div_s next_st;

   // count only while running so a frame started from idle begins on a full half period
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!tk.run) begin
         next_st.cnt = '0;
      end else if (st.cnt == 16'(HALF_DIV - 1)) begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end

   // register with synchronous reset
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tk.tick = st.tick;
endmodule

// [testbench/eeprom_dev_model.sv]
// behavioural serial eeprom with guard register, as seen on the host pins
`timescale 1ns/1ps
module eeprom_dev_model (
   input wire logic i_sel,
   input wire logic i_sck,
   input wire logic i_di,
   input wire logic i_wp,
   input wire logic i_gs,
   output logic o_do
);
   logic [15:0] mem [256]; // array, shipped all ones
   logic [15:0] wd [4]; // received data words
   logic [15:0] sh; // incoming data shifter
   logic [16:0] rsh; // outgoing bits, msb first
   logic [7:0] adr, grd, a; // frame address, guard boundary, page scratch
   logic [1:0] op;
   logic wen, arm, flag, frz, busy, mute, ok;
   int cnt, nw; // pulses since start bit, words received
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      {wen, arm, frz, busy, mute, o_do, op, adr} = '0; // locked at power up
      {flag, grd} = 9'h1ff;
      cnt = 0;
      nw = 0;
   end
   // frame start: status shows at once, ready stays one
   always @(posedge i_sel) begin
      cnt = 0;
      nw = 0;
      o_do = !busy && !mute;
   end
   // self-timed cycle, indifferent to the serial clock
   always @(posedge busy) begin
      #2000;
      busy = 0;
      if (i_sel) o_do = 1'b1;
   end
   // input sampled on the rising clock, ignored while busy
   always @(posedge i_sck) begin
      if (i_sel && !busy && (cnt > 0 || i_di)) begin
         cnt++;
         mute = 0;
         if (cnt <= 3) op = {op[0], i_di};
         else if (cnt <= 11) adr = {adr[6:0], i_di};
         else begin
            sh = {sh[14:0], i_di};
            if ((cnt - 11) % 16 == 0 && nw < 4) begin
               wd[nw] = sh;
               nw++;
            end
         end
         // read and fetch: dummy zero then data, lock state ignored
         if (cnt == 11) rsh = i_gs ? {1'b0, grd, flag, 7'h00} : {1'b0, mem[adr]};
         if (cnt >= 11) begin
            o_do = rsh[16];
            rsh = {rsh[15:0], 1'b0};
         end
      end
   end
   // decode at deselect; exact pulse counts except for the unlock and lock orders, rejects change nothing but arm and mute
   always @(negedge i_sel) begin
      o_do = ~o_do; // released line shows no stale level
      if (!busy && cnt > 0) begin
         ok = arm && i_wp && cnt == 11; // guard orders need unlock just before
         arm = 0;
         case ({i_gs, op})
            3'b000: begin
               if (adr[7:6] == 2'h3 && i_wp) wen = 1;
               if (adr[7:6] == 2'h0) wen = 0;
               if (adr[7:6] == 2'h1 && wen && flag && i_wp && cnt == 27) begin
                  foreach (mem[i]) mem[i] = wd[0];
                  busy = 1;
               end
            end
            3'b100: begin
               if (adr[7:6] == 2'h3) arm = wen && i_wp; // flag untouched
               if (adr == 8'h00 && ok) {frz, busy} = 2'b11;
            end
            3'b001: if (wen && i_wp && cnt == 27 && (flag || adr < grd)) begin
               mem[adr] = wd[0];
               busy = 1;
            end
            3'b101: if (ok && frz) mute = 1;
               else if (ok) {grd, flag, busy} = {adr, 2'b01};
            3'b111: if (ok && !frz) {grd, flag, busy} = 10'h3ff;
            3'b011: begin
               ok = wen && i_wp && nw > 0 && cnt == 11 + 16 * nw;
               for (int i = 0; i < nw; i++) if (!flag && {adr[7:2], adr[1:0] + 2'(i)} >= grd) ok = 0;
               a = adr;
               for (int i = 0; i < nw && ok; i++) begin
                  mem[a] = wd[i];
                  a[1:0] = a[1:0] + 2'h1;
               end
               busy = ok;
            end
            default: ;
         endcase
      end
   end
endmodule

// [testbench/test_eeprom_guard_host.sv]
// self-checking bench: ahb orders to the host, device model on the pins
`timescale 1ns/1ps
module test_eeprom_guard_host;
   logic clk, rst, hsel, hwrite, hready, hresp, sel, sck, di, wp, gs, dout, rd_dp;
   logic [31:0] haddr, hwdata, hrdata, last_rd;
   logic [1:0] htrans;
   logic [63:0] exp_q [$]; // mask and value of each pending read
   logic [63:0] e;
   logic [15:0] d [4]; // random data words
   int n_mismatch, n_compared;
   eeprom_guard_host #(.ADDR_W(8), .HALF_DIV(4), .POLL_MAX_CYC(2000)) u_dut (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_sel(sel), .o_sck(sck),
      .o_di(di), .o_wp(wp), .o_gs(gs), .i_do(dout));
   eeprom_dev_model u_dev (.i_sel(sel), .i_sck(sck), .i_di(di), .i_wp(wp), .i_gs(gs), .o_do(dout));
   // 200 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // data phase watcher: oldest note against each completed read
   always @(posedge clk) begin
      if (rd_dp && hready) begin
         last_rd = hrdata;
         e = exp_q.pop_front();
         if (e[63:32] != 32'h0) begin
            n_compared++;
            if ((hrdata & e[63:32]) !== e[31:0] || hresp !== 1'b0) begin
               n_mismatch++;
               $display("[FAIL] %0t read %h expected %h", $time, hrdata & e[63:32], e[31:0]);
            end
         end
      end
      if (rst) rd_dp <= 1'b0;
      else if (hready) rd_dp <= hsel && htrans[1] && !hwrite;
   end
   // one single ahb transfer; mask zero means no comparison
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v, input logic [31:0] m);
      if (!w) exp_q.push_back({m, v & m});
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (!hready) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge clk);
      while (!hready) @(posedge clk);
   endtask
   // issue an order and poll busy, bounded
   task automatic order(input logic [3:0] k, input logic [7:0] a, input logic [1:0] np, input logic lk = 1'b0);
      int i;
      bus(eeprom_host_pkg::OFS_CMD, 1'b1, {16'h0, a, 1'b0, lk, np, k}, 32'h0);
      repeat (3) @(posedge clk);
      i = 0;
      do begin
         bus(eeprom_host_pkg::OFS_STAT, 1'b0, 32'h0, 32'h0);
         #1;
         i++;
      end while (last_rd[0] !== 1'b0 && i < 3000);
      if (i >= 3000) begin
         n_mismatch++;
         $display("[FAIL] %0t order never finished", $time);
      end
   endtask
   task automatic rd_arr(input logic [7:0] a, input logic [15:0] v);
      order(eeprom_host_pkg::K_ARRAY_READ, a, 2'h0);
      bus(eeprom_host_pkg::OFS_RDAT, 1'b0, {16'h0, v}, 32'h1ffff);
   endtask
   task automatic fetch(input logic [7:0] g, input logic f);
      order(eeprom_host_pkg::K_GUARD_FETCH, 8'h00, 2'h0);
      bus(eeprom_host_pkg::OFS_RDAT, 1'b0, {23'h0, g, f}, 32'h3ff);
   endtask
   task automatic stat(input logic [31:0] v);
      bus(eeprom_host_pkg::OFS_STAT, 1'b0, v, 32'h1f);
   endtask
   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, well past the expected run length
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
   // main sequence
   initial begin
      {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
      n_mismatch = 0;
      n_compared = 0;
      void'($urandom(32'h0d1c));
      foreach (d[i]) d[i] = 16'($urandom());
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      stat(32'h0);
      bus(eeprom_host_pkg::OFS_WD01, 1'b1, {d[1], d[0]}, 32'h0);
      bus(eeprom_host_pkg::OFS_WD23, 1'b1, {d[3], d[2]}, 32'h0);
      order(eeprom_host_pkg::K_WORD_PROG, 8'h05, 2'h0);
      rd_arr(8'h05, 16'hffff);
      order(eeprom_host_pkg::K_PROG_UNLOCK, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_WORD_PROG, 8'h05, 2'h0);
      order(eeprom_host_pkg::K_PROG_LOCK, 8'h00, 2'h0);
      rd_arr(8'h05, d[0]);
      order(eeprom_host_pkg::K_GUARD_UNLOCK, 8'h00, 2'h0);
      stat(32'h2);
      order(eeprom_host_pkg::K_PROG_UNLOCK, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_GUARD_UNLOCK, 8'h00, 2'h0);
      stat(32'h18);
      fetch(8'hff, 1'b1);
      order(eeprom_host_pkg::K_GUARD_SET, 8'h7e, 2'h0);
      stat(32'ha);
      order(eeprom_host_pkg::K_GUARD_UNLOCK, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_GUARD_SET, 8'h7e, 2'h0);
      fetch(8'h7e, 1'b0);
      order(eeprom_host_pkg::K_WORD_PROG, 8'h7e, 2'h0);
      order(eeprom_host_pkg::K_WORD_PROG, 8'h7d, 2'h0);
      rd_arr(8'h7e, 16'hffff);
      rd_arr(8'h7d, d[0]);
      order(eeprom_host_pkg::K_PAGE_PROG, 8'h7c, 2'h3);
      rd_arr(8'h7c, 16'hffff);
      order(eeprom_host_pkg::K_PAGE_PROG, 8'h79, 2'h2);
      for (int i = 0; i < 3; i++) rd_arr(8'h79 + 8'(i), d[i]);
      order(eeprom_host_pkg::K_BULK_FILL, 8'h00, 2'h0);
      rd_arr(8'h00, 16'hffff);
      order(eeprom_host_pkg::K_GUARD_UNLOCK, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_GUARD_RESET, 8'h00, 2'h0);
      fetch(8'hff, 1'b1);
      order(eeprom_host_pkg::K_BULK_FILL, 8'h00, 2'h0);
      rd_arr(8'h7e, d[0]);
      order(eeprom_host_pkg::K_GUARD_UNLOCK, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_GUARD_FREEZE, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_GUARD_UNLOCK, 8'h00, 2'h0);
      order(eeprom_host_pkg::K_GUARD_SET, 8'h10, 2'h0);
      stat(32'hc);
      fetch(8'hff, 1'b1);
      bus(eeprom_host_pkg::OFS_WD01, 1'b1, {d[1], ~d[0]}, 32'h0);
      order(eeprom_host_pkg::K_WORD_PROG, 8'h20, 2'h0, 1'b1);
      stat(32'h0);
      rd_arr(8'h20, ~d[0]);
      order(eeprom_host_pkg::K_PAGE_PROG, 8'h7a, 2'h3);
      stat(32'h2);
      complete_run();
   end
endmodule
